// ### core/arf_regs.sv
// ADC result formatting and control registers behind an AXI4-Lite slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
module arf_regs
    import arf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conv_done,
    input wire logic [9:0] conversion_result,
    output logic conv_start,
    output logic converter_enable,
    output logic [4:0] channel_sel,
    output logic [2:0] conv_clock_sel,
    output logic neg_ref_sel,
    output logic [1:0] pos_ref_sel
);
    logic aw_have_q;
    logic [31:0] awaddr_q;
    logic w_have_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic [7:0] ctrl0_q;
    logic go_q;
    logic [7:0] ctrl1_q;
    logic [7:0] res_hi_q;
    logic [7:0] res_lo_q;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_fire;
    logic wr_hit;
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_res_hi;
    logic wr_res_lo;
    logic done_evt;
    logic fmt_right;
    logic [31:0] rd_word;
    logic rd_known;

    // Address decode shared by the write response
    function automatic logic known_addr(
        input logic [31:0] a
    );
        return (a == ARF_OFS_CTRL0)
            || (a == ARF_OFS_CTRL1)
            || (a == ARF_OFS_RES_HI)
            || (a == ARF_OFS_RES_LO);
    endfunction

    // High result byte for the selected justification
    function automatic logic [7:0] fmt_high(
        input logic [9:0] res,
        input logic right
    );
        logic [7:0] val;
        if (right) begin
            val = {6'h00, res[9:8]};
        end else begin
            val = res[9:2];
        end
        return val;
    endfunction

    // Low result byte for the selected justification
    function automatic logic [7:0] fmt_low(
        input logic [9:0] res,
        input logic right
    );
        logic [7:0] val;
        if (right) begin
            val = res[7:0];
        end else begin
            val = {res[1:0], 6'h00};
        end
        return val;
    endfunction

    // Byte-wide register placed in the low byte of a bus word
    function automatic logic [31:0] bus_word(
        input logic [7:0] b
    );
        return {24'h00_0000, b};
    endfunction

    // Ready while the holding register is empty and no response waits
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // Write commits once both address and data are held
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_hit = wr_fire && wstrb0_q;
    assign wr_ctrl0 = wr_hit && (awaddr_q == ARF_OFS_CTRL0);
    assign wr_ctrl1 = wr_hit && (awaddr_q == ARF_OFS_CTRL1);
    assign wr_res_hi = wr_hit && (awaddr_q == ARF_OFS_RES_HI);
    assign wr_res_lo = wr_hit && (awaddr_q == ARF_OFS_RES_LO);

    // Conversion end only counts while the start bit is set
    assign done_evt = go_q && conv_done;
    assign fmt_right = ctrl1_q[ARF_FMT_BIT];

    // Write address holding flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_have_q <= 1'b0;
        end else if (aw_take) begin
            aw_have_q <= 1'b1;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    // Write address capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awaddr_q <= 32'h0000_0000;
        end else if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
        end
    end

    // Write data holding flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            w_have_q <= 1'b0;
        end else if (w_take) begin
            w_have_q <= 1'b1;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    // Only byte 0 of the write data is used
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdata_q <= 8'h00;
        end else if (w_take) begin
            wdata_q <= s_axi_wdata[7:0];
        end
    end

    // Byte 0 strobe; a write without it changes nothing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wstrb0_q <= 1'b0;
        end else if (w_take) begin
            wstrb0_q <= s_axi_wstrb[0];
        end
    end

    // Write response valid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Write response code
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_bresp <= ARF_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bresp <= known_addr(awaddr_q) ? ARF_RESP_OKAY : ARF_RESP_SLVERR;
        end
    end

    // Control register 0
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl0_q <= ARF_CTRL0_RST;
        end else if (wr_ctrl0) begin
            ctrl0_q <= wdata_q & ARF_CTRL0_MASK;
        end
    end

    // Start/done bit; conversion end beats a same-cycle write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            go_q <= 1'b0;
        end else if (done_evt) begin
            go_q <= 1'b0;
        end else if (wr_ctrl0) begin
            go_q <= wdata_q[ARF_GO_BIT];
        end
    end

    // Control register 1
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl1_q <= ARF_CTRL1_RST;
        end else if (wr_ctrl1) begin
            ctrl1_q <= wdata_q & ARF_CTRL1_MASK;
        end
    end

    // Result high survives sys_rst; only power-on reset touches it
    always_ff @(posedge clk) begin
        if (por_rst) begin
            res_hi_q <= 8'h00;
        end else if (done_evt) begin
            res_hi_q <= fmt_high(conversion_result, fmt_right);
        end else if (wr_res_hi) begin
            res_hi_q <= wdata_q;
        end
    end

    // Result low survives sys_rst; only power-on reset touches it
    always_ff @(posedge clk) begin
        if (por_rst) begin
            res_lo_q <= 8'h00;
        end else if (done_evt) begin
            res_lo_q <= fmt_low(conversion_result, fmt_right);
        end else if (wr_res_lo) begin
            res_lo_q <= wdata_q;
        end
    end

    // Read data selection; unmapped reads return zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b1;
        unique case (s_axi_araddr)
            ARF_OFS_CTRL0: begin
                rd_word = bus_word({ctrl0_q[7:2], go_q, ctrl0_q[0]});
            end
            ARF_OFS_CTRL1: begin
                rd_word = bus_word(ctrl1_q);
            end
            ARF_OFS_RES_HI: begin
                rd_word = bus_word(res_hi_q);
            end
            ARF_OFS_RES_LO: begin
                rd_word = bus_word(res_lo_q);
            end
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    // Read response valid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Read response code
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rresp <= ARF_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rresp <= rd_known ? ARF_RESP_OKAY : ARF_RESP_SLVERR;
        end
    end

    // Read data, held until the response is accepted
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rdata <= 32'h0000_0000;
        end else if (ar_take) begin
            s_axi_rdata <= rd_word;
        end
    end

    // Acquisition wait before start is left to software
    assign conv_start = go_q;
    assign converter_enable = ctrl0_q[ARF_EN_BIT];
    assign channel_sel = ctrl0_q[6:ARF_CH_LSB];
    assign conv_clock_sel = ctrl1_q[6:ARF_CS_LSB];
    assign neg_ref_sel = ctrl1_q[ARF_NREF_BIT];
    assign pos_ref_sel = ctrl1_q[1:ARF_PREF_LSB];
endmodule

// ### core/arf_pkg.sv
// Constants for the ADC result format and control register block
package arf_pkg;
    localparam logic [31:0] ARF_OFS_CTRL0 = 32'h0000_0000;
    localparam logic [31:0] ARF_OFS_CTRL1 = 32'h0000_0004;
    localparam logic [31:0] ARF_OFS_RES_HI = 32'h0000_0008;
    localparam logic [31:0] ARF_OFS_RES_LO = 32'h0000_000C;
    localparam int ARF_CH_LSB = 2;
    localparam int ARF_GO_BIT = 1;
    localparam int ARF_EN_BIT = 0;
    localparam int ARF_FMT_BIT = 7;
    localparam int ARF_CS_LSB = 4;
    localparam int ARF_NREF_BIT = 2;
    localparam int ARF_PREF_LSB = 0;
    localparam logic [7:0] ARF_CTRL0_RST = 8'h00;
    localparam logic [7:0] ARF_CTRL1_RST = 8'h00;
    localparam logic [7:0] ARF_CTRL0_MASK = 8'h7F;
    localparam logic [7:0] ARF_CTRL1_MASK = 8'hF7;
    localparam logic [1:0] ARF_RESP_OKAY = 2'h0;
    localparam logic [1:0] ARF_RESP_SLVERR = 2'h2;
endpackage

// ### test/arf_regs_checker.sv
// Port checker for the result and control register block
module arf_regs_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conv_done,
    input wire logic conv_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_done_clears: assert property (conv_start && conv_done |=> !conv_start)
        else $error("start bit kept");
    a_start_write: assert property ($rose(conv_start) |-> $rose(s_axi_bvalid))
        else $error("start without write");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("rdata changed");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper bits set");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready while busy");
    a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready while busy");
endmodule
bind arf_regs arf_regs_checker chk (.*);

// ### test/arf_regs_tb.sv
// Self-checking bench for the result and control register block
module arf_regs_tb
    import arf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, sys_rst = 1, por_rst = 1, conv_done = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, q, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [9:0] conversion_result = 0;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_start, converter_enable, neg_ref_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, pos_ref_sel, r, b;
    logic [4:0] channel_sel;
    logic [2:0] conv_clock_sel;
    logic [7:0] d0, d1, hi, lo;
    int errors = 0, checks_done = 0, seed = 32'h73bfc00f;
    always #12.5 clk = ~clk;
    arf_regs uut (.*);
    task automatic chk(input logic [31:0] e, s, input string n);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        b = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        {q, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge clk);
        {sys_rst, por_rst} <= 2'h0;
        rd(ARF_OFS_RES_HI);
        chk(q, 32'h0, "power-on result");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            d1 = {i[0], v[6:0]};
            d0 = v[15:8] | 8'h03;
            wr(ARF_OFS_CTRL1, d1);
            rd(ARF_OFS_CTRL1);
            chk(q, {24'h0, d1 & ARF_CTRL1_MASK}, "ctrl1");
            chk({conv_clock_sel, 1'b0, neg_ref_sel, pos_ref_sel}, d1 & 8'h77, "cfg pins");
            wr(ARF_OFS_CTRL0, d0 & 8'hFD);
            repeat (4) @(posedge clk);
            wr(ARF_OFS_CTRL0, d0);
            chk(b, ARF_RESP_OKAY, "write resp");
            chk({channel_sel, conv_start, converter_enable}, d0 & 8'h7F, "ctrl0 pins");
            {conversion_result, conv_done} <= {v[25:16], 1'h1};
            @(posedge clk);
            conv_done <= 1'h0;
            hi = i[0] ? {6'h0, v[25:24]} : v[25:18];
            lo = i[0] ? v[23:16] : {v[17:16], 6'h0};
            rd(ARF_OFS_RES_HI);
            chk(q, {24'h0, hi}, "result high");
            rd(ARF_OFS_RES_LO);
            chk(q, {24'h0, lo}, "result low");
            rd(ARF_OFS_CTRL0);
            chk(q, {24'h0, d0 & 8'h7D}, "ctrl0");
            $display("conversion test %0d done", i);
        end
        wr(ARF_OFS_RES_LO, 8'hA5);
        sys_rst <= 1'h1;
        @(posedge clk);
        sys_rst <= 1'h0;
        rd(ARF_OFS_RES_LO);
        chk(q, 32'hA5, "kept result");
        s_axi_wstrb <= 4'hE;
        wr(ARF_OFS_RES_LO, 8'h3C);
        chk(b, ARF_RESP_OKAY, "masked write resp");
        s_axi_wstrb <= 4'hF;
        rd(ARF_OFS_RES_LO);
        chk(q, 32'hA5, "masked write");
        wr(32'h10, 8'h5A);
        chk(b, ARF_RESP_SLVERR, "unmapped write resp");
        rd(ARF_OFS_CTRL0);
        chk(q, 32'h0, "ctrl0 reset");
        rd(32'h10);
        chk({q[29:0], r}, {30'h0, ARF_RESP_SLVERR}, "unmapped");
        $display("register test done");
        give_verdict;
    end
endmodule
